/* hdl/lcdr_pkg.sv */
// lcdr_pkg: constants, opcodes and types of the display reset and power configuration block.
// assumes a single 250 MHz clock; the command decoder feeding this block is a plain AHB-Lite register.
package lcdr_pkg;
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned RST_CMD_NS = 1000;
	localparam int unsigned RST_CMD_CYC = (RST_CMD_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned LINE_NS = 4000;
	localparam int unsigned LINE_CYC = (LINE_NS * CLK_MHZ) / 1000;
	localparam int unsigned SEG_CH = 132;
	localparam int unsigned COM_CH = 66;
	localparam int unsigned COM_MAIN = 64;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_CFG = 8'h08;
	localparam logic [7:0] ADDR_POS = 8'h0c;
	localparam logic [7:0] ADDR_PINS = 8'h10;
	localparam int unsigned ST_BUSY = 7;
	localparam int unsigned ST_ADC = 6;
	localparam int unsigned ST_OFF = 5;
	localparam int unsigned ST_RESET = 4;

	// ---------------------------------------------------------------
	// reset values and tables
	// ---------------------------------------------------------------
	localparam logic [5:0] CONTRAST_RST = 6'h20;
	localparam logic [2:0] RATIO_RST = 3'h4;
	localparam logic [6:0] DUTY_33 = 7'h21;
	localparam logic [6:0] DUTY_49 = 7'h31;
	localparam logic [6:0] DUTY_55 = 7'h37;
	localparam logic [6:0] DUTY_65 = 7'h41;

	// ---------------------------------------------------------------
	// command opcodes (casez patterns)
	// ---------------------------------------------------------------
	localparam logic [7:0] OP_DISPLAY = 8'b1010_111?;
	localparam logic [7:0] OP_START = 8'b01??_????;
	localparam logic [7:0] OP_CONTRAST = 8'h81;
	localparam logic [7:0] OP_PAGE = 8'b1011_????;
	localparam logic [7:0] OP_COL_HI = 8'b0001_????;
	localparam logic [7:0] OP_COL_LO = 8'b0000_????;
	localparam logic [7:0] OP_SEG_DIR = 8'b1010_000?;
	localparam logic [7:0] OP_BIAS = 8'b1010_001?;
	localparam logic [7:0] OP_ALL_ON = 8'b1010_010?;
	localparam logic [7:0] OP_INVERT = 8'b1010_011?;
	localparam logic [7:0] OP_INDICATOR = 8'b1010_110?;
	localparam logic [7:0] OP_MODIFY_ON = 8'he0;
	localparam logic [7:0] OP_MODIFY_OFF = 8'hee;
	localparam logic [7:0] OP_RESET = 8'he2;
	localparam logic [7:0] OP_SCAN = 8'b1100_????;
	localparam logic [7:0] OP_POWER = 8'b0010_1???;
	localparam logic [7:0] OP_RATIO = 8'b0010_0???;
	localparam logic [7:0] OP_TEST_A = 8'b1111_????;
	localparam logic [7:0] OP_TEST_B = 8'b1001_????;

	// ---------------------------------------------------------------
	// drive level codes
	// ---------------------------------------------------------------
	localparam logic [2:0] LV_V0 = 3'h0;
	localparam logic [2:0] LV_V1 = 3'h1;
	localparam logic [2:0] LV_V2 = 3'h2;
	localparam logic [2:0] LV_V3 = 3'h3;
	localparam logic [2:0] LV_V4 = 3'h4;
	localparam logic [2:0] LV_VSS = 3'h5;
	localparam logic [2:0] LV_NC = 3'h7;

	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_CMDRST = 2'b01,
		ST_PINRST = 2'b10
	} lcdr_state_t;

	typedef struct packed {
		logic displayOn;
		logic allOn;
		logic segReverse;
		logic invertPixels;
		logic bias;
		logic [2:0] powerEn;
		logic modifyRead;
		logic staticInd;
		logic [1:0] indicatorState;
		logic commonScanReverse;
		logic [5:0] startLine;
		logic [7:0] column;
		logic [3:0] page;
		logic [2:0] ratio;
		logic [5:0] contrast;
		logic contrastEntry;
		logic indicatorEntry;
		logic testMode;
	} lcdr_cfg_t;

	typedef struct packed {
		logic resetN;
		logic primary;
		logic internalDiv;
		logic dutyHi;
		logic dutyLo;
		logic highDriveN;
	} lcdr_pins_t;

	localparam lcdr_cfg_t CFG_RST = '{ratio: RATIO_RST, contrast: CONTRAST_RST, default: '0};
endpackage : lcdr_pkg

/* hdl/lcdr_sync.sv */
// lcdr_sync: two-flop synchroniser for pin levels.
// assumes inputs are quasi-static levels; no pulse is shorter than two clocks.
module lcdr_sync #(
	parameter int unsigned W = 6
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// levels
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			dout <= '0;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule : lcdr_sync

/* hdl/lcdr_drive.sv */
// lcdr_drive: per-channel level selection for segment and common outputs.
// assumes line index and alternation come from the frame divider of the top.
module lcdr_drive #(
	parameter int unsigned SEGS = lcdr_pkg::SEG_CH,
	parameter int unsigned ICON_COMMON_OUTPUTS = lcdr_pkg::COM_CH
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// display state
	input wire logic [SEGS-1:0] pixelRow,
	input wire logic [6:0] lineCnt,
	input wire logic [6:0] dutyLines,
	input wire logic alternation,
	input wire logic displayOn,
	input wire logic allOn,
	input wire logic invertPixels,
	input wire logic segReverse,
	input wire logic commonScanReverse,
	// channel levels
	output logic [SEGS-1:0][2:0] segLevel,
	output logic [ICON_COMMON_OUTPUTS-1:0][2:0] comLevel
);
	logic [SEGS-1:0][2:0] segLevel_d;
	logic [ICON_COMMON_OUTPUTS-1:0][2:0] comLevel_d;
	logic [6:0] half;
	logic [6:0] ln;
	logic [6:0] pin;
	logic isIcon;
	logic on;
	logic sel;

	always_comb begin
		half = (dutyLines - 7'h01) >> 1;
		isIcon = (lineCnt == dutyLines - 7'h01);
		ln = commonScanReverse ? 7'((half << 1) - 7'h01 - lineCnt) : lineCnt;
		pin = (ln < half) ? ln : 7'(7'(lcdr_pkg::COM_MAIN) - (half << 1) + ln);
		on = 1'b0;
		sel = 1'b0;
		for (int i = 0; i < SEGS; i++) begin
			on = allOn | ((segReverse ? pixelRow[SEGS-1-i] : pixelRow[i]) ^ invertPixels);
			if (!displayOn)
				segLevel_d[i] = lcdr_pkg::LV_VSS;
			else if (on)
				segLevel_d[i] = alternation ? lcdr_pkg::LV_V0 : lcdr_pkg::LV_VSS;
			else
				segLevel_d[i] = alternation ? lcdr_pkg::LV_V2 : lcdr_pkg::LV_V3;
		end
		for (int j = 0; j < ICON_COMMON_OUTPUTS; j++) begin
			// icon commons sit above the main 64 and carry the last line of the duty
			sel = (j >= lcdr_pkg::COM_MAIN) ? isIcon : (!isIcon && pin == 7'(j));
			if (j < lcdr_pkg::COM_MAIN && 7'(j) >= half && 7'(j) < 7'(7'(lcdr_pkg::COM_MAIN) - half))
				comLevel_d[j] = lcdr_pkg::LV_NC;
			else if (!displayOn)
				comLevel_d[j] = lcdr_pkg::LV_VSS;
			else if (sel)
				comLevel_d[j] = alternation ? lcdr_pkg::LV_VSS : lcdr_pkg::LV_V0;
			else
				comLevel_d[j] = alternation ? lcdr_pkg::LV_V4 : lcdr_pkg::LV_V1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			segLevel <= '0;
			comLevel <= '0;
		end else begin
			segLevel <= segLevel_d;
			comLevel <= comLevel_d;
		end
	end
endmodule : lcdr_drive

/* hdl/lcdr_top.sv */
// lcdr_top: reset sequencing, command state and power configuration of the display driver.
// assumes one 250 MHz clock, an AHB-Lite master with single word transfers, and pins
// from outside the clock domain that are synchronised here before use.
//
// Added by the designer: the AHB-Lite interface to the registers and the register addresses.
module lcdr_top #(
	parameter int unsigned SEGS = lcdr_pkg::SEG_CH,
	parameter int unsigned ICON_COMMON_OUTPUTS = lcdr_pkg::COM_CH,
	parameter int unsigned RST_CYC = lcdr_pkg::RST_CMD_CYC,
	parameter int unsigned LINE_DIV = lcdr_pkg::LINE_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// pins
	input wire logic resetPinN,
	input wire logic primarySecondarySelect,
	input wire logic internalDividerSelect,
	input wire logic dutySelectHi,
	input wire logic dutySelectLo,
	input wire logic highDriveModeN,
	// display data row for the current line
	input wire logic [SEGS-1:0] pixelRow,
	// power and analog configuration
	output logic boosterEnable,
	output logic regulatorEnable,
	output logic followerEnable,
	output logic [5:0] contrastLevel,
	output logic [2:0] dividerRatioCode,
	output logic [6:0] regulatorGainX10,
	output logic useInternalDivider,
	output logic [6:0] dutyDenom,
	output logic [3:0] biasDenom,
	output logic highPowerMode,
	// timing and status
	output logic oscRunning,
	output logic alternationSignal,
	output logic [6:0] lineIndex,
	output logic [5:0] displayLine,
	output logic serialClear,
	output logic powerSave,
	output logic staticIndicator,
	output logic [1:0] indicatorState,
	// channel levels
	output logic [SEGS-1:0][2:0] segLevel,
	output logic [ICON_COMMON_OUTPUTS-1:0][2:0] comLevel
);
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic lcdr_pkg::lcdr_cfg_t cmd_reset(input lcdr_pkg::lcdr_cfg_t c);
		lcdr_pkg::lcdr_cfg_t r;
		r = c;
		r.modifyRead = 1'b0;
		r.staticInd = 1'b0;
		r.indicatorState = 2'h0;
		r.commonScanReverse = 1'b0;
		r.startLine = 6'h00;
		r.column = 8'h00;
		r.page = 4'h0;
		r.ratio = lcdr_pkg::RATIO_RST;
		r.contrast = lcdr_pkg::CONTRAST_RST;
		r.contrastEntry = 1'b0;
		r.indicatorEntry = 1'b0;
		r.testMode = 1'b0;
		return r;
	endfunction : cmd_reset

	function automatic lcdr_pkg::lcdr_cfg_t pin_reset(input lcdr_pkg::lcdr_cfg_t c);
		lcdr_pkg::lcdr_cfg_t r;
		r = cmd_reset(c);
		r.displayOn = 1'b0;
		r.allOn = 1'b0;
		r.segReverse = 1'b0;
		r.invertPixels = 1'b0;
		r.powerEn = 3'h0;
		r.bias = 1'b0;
		return r;
	endfunction : pin_reset

	function automatic lcdr_pkg::lcdr_cfg_t cmd_apply(input lcdr_pkg::lcdr_cfg_t c, input logic [7:0] b);
		lcdr_pkg::lcdr_cfg_t r;
		r = c;
		if (c.contrastEntry) begin
			r.contrast = b[5:0];
			r.contrastEntry = 1'b0;
		end else if (c.indicatorEntry) begin
			r.indicatorState = b[1:0];
			r.indicatorEntry = 1'b0;
		end else begin
			casez (b)
				lcdr_pkg::OP_DISPLAY: r.displayOn = b[0];
				lcdr_pkg::OP_START: r.startLine = b[5:0];
				lcdr_pkg::OP_CONTRAST: r.contrastEntry = 1'b1;
				lcdr_pkg::OP_PAGE: r.page = b[3:0];
				lcdr_pkg::OP_COL_HI: r.column[7:4] = b[3:0];
				lcdr_pkg::OP_COL_LO: r.column[3:0] = b[3:0];
				lcdr_pkg::OP_SEG_DIR: r.segReverse = b[0];
				lcdr_pkg::OP_BIAS: r.bias = b[0];
				lcdr_pkg::OP_ALL_ON: r.allOn = b[0];
				lcdr_pkg::OP_INVERT: r.invertPixels = b[0];
				lcdr_pkg::OP_INDICATOR: begin
					r.staticInd = b[0];
					r.indicatorEntry = 1'b1;
				end
				lcdr_pkg::OP_MODIFY_ON: r.modifyRead = 1'b1;
				lcdr_pkg::OP_MODIFY_OFF: r.modifyRead = 1'b0;
				lcdr_pkg::OP_SCAN: r.commonScanReverse = b[3];
				lcdr_pkg::OP_POWER: r.powerEn = b[2:0];
				lcdr_pkg::OP_RATIO: r.ratio = b[2:0];
				lcdr_pkg::OP_TEST_A: r.testMode = 1'b1;
				lcdr_pkg::OP_TEST_B: r.testMode = 1'b1;
				default: r = c;
			endcase
		end
		return r;
	endfunction : cmd_apply

	function automatic logic [6:0] gain_x10(input logic [2:0] code);
		case (code)
			3'h0: gain_x10 = 7'd30;
			3'h1: gain_x10 = 7'd35;
			3'h2: gain_x10 = 7'd40;
			3'h3: gain_x10 = 7'd45;
			3'h4: gain_x10 = 7'd50;
			3'h5: gain_x10 = 7'd55;
			3'h6: gain_x10 = 7'd60;
			default: gain_x10 = 7'd64;
		endcase
	endfunction : gain_x10

	function automatic logic [6:0] duty_lines(input logic hi, input logic lo);
		case ({hi, lo})
			2'b00: duty_lines = lcdr_pkg::DUTY_33;
			2'b01: duty_lines = lcdr_pkg::DUTY_49;
			2'b10: duty_lines = lcdr_pkg::DUTY_55;
			default: duty_lines = lcdr_pkg::DUTY_65;
		endcase
	endfunction : duty_lines

	function automatic logic [3:0] bias_denom(input logic hi, input logic lo, input logic bias);
		case ({hi, lo})
			2'b00: bias_denom = bias ? 4'd5 : 4'd6;
			2'b11: bias_denom = bias ? 4'd7 : 4'd9;
			default: bias_denom = bias ? 4'd6 : 4'd8;
		endcase
	endfunction : bias_denom

	// ---------------------------------------------------------------
	// pin synchronisation
	// ---------------------------------------------------------------
	lcdr_pkg::lcdr_pins_t pins;

	lcdr_sync #(
		.W(6)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.din({resetPinN, primarySecondarySelect, internalDividerSelect, dutySelectHi, dutySelectLo, highDriveModeN}),
		.dout(pins)
	);

	logic pinReset;
	assign pinReset = ~pins.resetN;

	// ---------------------------------------------------------------
	// bus slave
	// ---------------------------------------------------------------
	logic wrPend_q, wrPend_d;
	logic [7:0] wrAddr_q, wrAddr_d;
	logic [31:0] hrdata_q, hrdata_d;
	lcdr_pkg::lcdr_cfg_t cfg_q, cfg_d;
	lcdr_pkg::lcdr_state_t state_q, state_d;
	logic [11:0] cnt_q, cnt_d;
	logic addrPhase;
	logic busy;
	logic cmdWrite;

	assign busy = pinReset || state_q != lcdr_pkg::ST_RUN;
	assign addrPhase = hsel && hready && htrans[1];
	// a byte of command is only taken while idle; status stays readable
	assign cmdWrite = wrPend_q && wrAddr_q == lcdr_pkg::ADDR_CMD && !busy;

	always_comb begin
		wrPend_d = addrPhase && hwrite;
		wrAddr_d = addrPhase ? haddr[7:0] : wrAddr_q;
		hrdata_d = hrdata_q;
		if (addrPhase && !hwrite) begin
			case (haddr[7:0])
				lcdr_pkg::ADDR_STATUS: begin
					hrdata_d = 32'h0000_0000;
					hrdata_d[lcdr_pkg::ST_BUSY] = busy;
					hrdata_d[lcdr_pkg::ST_ADC] = ~cfg_q.segReverse;
					hrdata_d[lcdr_pkg::ST_OFF] = ~cfg_q.displayOn;
					hrdata_d[lcdr_pkg::ST_RESET] = busy;
				end
				lcdr_pkg::ADDR_CFG: hrdata_d = {4'h0, cfg_q.segReverse, cfg_q.invertPixels, cfg_q.allOn,
					cfg_q.displayOn, cfg_q.testMode, cfg_q.contrastEntry, cfg_q.indicatorState, cfg_q.staticInd,
					cfg_q.modifyRead, cfg_q.commonScanReverse, cfg_q.bias, 1'b0, cfg_q.powerEn, 1'b0,
					cfg_q.ratio, 2'h0, cfg_q.contrast};
				lcdr_pkg::ADDR_POS: hrdata_d = {12'h000, cfg_q.page, cfg_q.column, 2'h0, cfg_q.startLine};
				lcdr_pkg::ADDR_PINS: hrdata_d = {26'h0000000, pins};
				default: hrdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPend_q <= 1'b0;
			wrAddr_q <= 8'h00;
			hrdata_q <= 32'h0000_0000;
		end else begin
			wrPend_q <= wrPend_d;
			wrAddr_q <= wrAddr_d;
			hrdata_q <= hrdata_d;
		end
	end

	assign hrdata = hrdata_q;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// ---------------------------------------------------------------
	// reset sequencing and command state
	// ---------------------------------------------------------------
	always_comb begin
		cfg_d = cfg_q;
		state_d = state_q;
		cnt_d = cnt_q;
		if (pinReset) begin
			cfg_d = pin_reset(cfg_q);
			state_d = lcdr_pkg::ST_PINRST;
		end else begin
			case (state_q)
				lcdr_pkg::ST_RUN: begin
					if (cmdWrite) begin
						// a reset opcode inside a two-byte entry is data, not a reset
						if (hwdata[7:0] == lcdr_pkg::OP_RESET && !cfg_q.contrastEntry && !cfg_q.indicatorEntry) begin
							cfg_d = cmd_reset(cfg_q);
							state_d = lcdr_pkg::ST_CMDRST;
							cnt_d = 12'(RST_CYC - 1);
						end else begin
							cfg_d = cmd_apply(cfg_q, hwdata[7:0]);
						end
					end
				end
				lcdr_pkg::ST_CMDRST: begin
					cnt_d = cnt_q - 12'h001;
					if (cnt_q == 12'h000)
						state_d = lcdr_pkg::ST_RUN;
				end
				lcdr_pkg::ST_PINRST: state_d = lcdr_pkg::ST_RUN;
				default: state_d = lcdr_pkg::ST_RUN;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q <= lcdr_pkg::CFG_RST;
			state_q <= lcdr_pkg::ST_PINRST;
			cnt_q <= 12'h000;
		end else begin
			cfg_q <= cfg_d;
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	// ---------------------------------------------------------------
	// frame divider and alternation
	// ---------------------------------------------------------------
	logic [11:0] div_q, div_d;
	logic [6:0] line_q, line_d;
	logic alt_q, alt_d;
	logic [5:0] frameStart_q, frameStart_d;
	logic [6:0] dutyLines;
	logic lineTick;

	assign dutyLines = duty_lines(pins.dutyHi, pins.dutyLo);
	assign lineTick = !pinReset && div_q == 12'(LINE_DIV - 1);

	always_comb begin
		div_d = div_q;
		line_d = line_q;
		alt_d = alt_q;
		frameStart_d = frameStart_q;
		if (!pinReset) begin
			div_d = lineTick ? 12'h000 : div_q + 12'h001;
			if (lineTick) begin
				if (line_q >= dutyLines - 7'h01) begin
					line_d = 7'h00;
					alt_d = ~alt_q;
					frameStart_d = cfg_q.startLine;
				end else begin
					line_d = line_q + 7'h01;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= 12'h000;
			line_q <= 7'h00;
			alt_q <= 1'b0;
			frameStart_q <= 6'h00;
		end else begin
			div_q <= div_d;
			line_q <= line_d;
			alt_q <= alt_d;
			frameStart_q <= frameStart_d;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign boosterEnable = cfg_q.powerEn[2] & pins.primary;
	assign regulatorEnable = cfg_q.powerEn[1] & pins.primary;
	assign followerEnable = cfg_q.powerEn[0] & pins.primary;
	assign contrastLevel = cfg_q.contrast;
	assign dividerRatioCode = cfg_q.ratio;
	assign useInternalDivider = pins.internalDiv;
	assign regulatorGainX10 = pins.internalDiv ? gain_x10(cfg_q.ratio) : 7'h00;
	assign dutyDenom = dutyLines;
	assign biasDenom = bias_denom(pins.dutyHi, pins.dutyLo, cfg_q.bias);
	assign highPowerMode = ~pins.highDriveN;
	assign oscRunning = ~pinReset;
	assign alternationSignal = alt_q;
	assign lineIndex = line_q;
	assign displayLine = 6'(frameStart_q + line_q[5:0]);
	assign serialClear = pinReset;
	assign powerSave = ~cfg_q.displayOn & cfg_q.allOn;
	assign staticIndicator = cfg_q.staticInd;
	assign indicatorState = cfg_q.indicatorState;

	lcdr_drive #(
		.SEGS(SEGS),
		.ICON_COMMON_OUTPUTS(ICON_COMMON_OUTPUTS)
	) u_drive (
		.clk(clk),
		.rst_n(rst_n),
		.pixelRow(pixelRow),
		.lineCnt(line_q),
		.dutyLines(dutyLines),
		.alternation(alt_q),
		.displayOn(cfg_q.displayOn),
		.allOn(cfg_q.allOn),
		.invertPixels(cfg_q.invertPixels),
		.segReverse(cfg_q.segReverse),
		.commonScanReverse(cfg_q.commonScanReverse),
		.segLevel(segLevel),
		.comLevel(comLevel)
	);
endmodule : lcdr_top

/* sim/lcdr_checker.sv */
// lcdr_checker: port-level properties of the reset and power block.
// assumes it is bound to lcdr_top; pins pass a two-flop synchroniser first.
module lcdr_checker (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// pins
	input wire logic resetPinN,
	input wire logic primarySecondarySelect,
	input wire logic highDriveModeN,
	// outputs
	input wire logic boosterEnable,
	input wire logic regulatorEnable,
	input wire logic followerEnable,
	input wire logic [5:0] contrastLevel,
	input wire logic [2:0] dividerRatioCode,
	input wire logic [6:0] regulatorGainX10,
	input wire logic useInternalDivider,
	input wire logic [6:0] dutyDenom,
	input wire logic [3:0] biasDenom,
	input wire logic highPowerMode,
	input wire logic oscRunning,
	input wire logic serialClear
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// five samples: sync latency plus one register, with a cycle spare
	property p_osc; !resetPinN [*5] |-> !oscRunning && serialClear; endproperty
	a_osc: assert property (p_osc) else $error("oscillator or serial state live in pin reset");
	property p_pclr; !resetPinN [*5] |-> !(boosterEnable || regulatorEnable || followerEnable); endproperty
	a_pclr: assert property (p_pclr) else $error("power enables live in pin reset");
	property p_prst; !resetPinN [*5] |-> contrastLevel == 6'h20 && dividerRatioCode == 3'h4; endproperty
	a_prst: assert property (p_prst) else $error("contrast or ratio not at reset value");
	property p_prim; !primarySecondarySelect [*5] |-> !(boosterEnable || regulatorEnable || followerEnable); endproperty
	a_prim: assert property (p_prim) else $error("power enable on secondary chip");
	property p_gain; useInternalDivider |->
		regulatorGainX10 == (dividerRatioCode == 3'h7 ? 7'h40 : 7'h1e + 7'h5 * dividerRatioCode); endproperty
	a_gain: assert property (p_gain) else $error("gain does not follow ratio code");
	property p_ext; !useInternalDivider |-> regulatorGainX10 == 7'h0; endproperty
	a_ext: assert property (p_ext) else $error("internal gain with external divider");
	property p_hpm; $stable(highDriveModeN) [*5] |-> highPowerMode == !highDriveModeN; endproperty
	a_hpm: assert property (p_hpm) else $error("power mode does not follow pin");
	property p_duty; dutyDenom == 7'h41 |-> biasDenom == 4'h9 || biasDenom == 4'h7; endproperty
	a_duty: assert property (p_duty) else $error("bias not valid for duty 65");
endmodule : lcdr_checker

/* sim/lcdr_host.sv */
// lcdr_host: host-side reset wiring of the display block.
// assumes the bench requests extra pin resets through pinRstReq.
module lcdr_host (
	// resets
	input wire logic hostRstN,
	input wire logic pinRstReq,
	// device pin
	output logic resetPinN
);
	timeunit 1ns;
	timeprecision 1ps;
	// device never starts ahead of the host
	assign resetPinN = hostRstN & ~pinRstReq;
endmodule : lcdr_host

/* sim/lcdr_top_tb.sv */
// lcdr_top_tb: command-level tests of the reset and power block.
// assumes a zero-wait AHB-Lite slave and the host model on the reset pin.
module lcdr_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic pinRstReq = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic primarySecondarySelect = 1'b1;
	logic internalDividerSelect = 1'b1;
	logic dutySelectHi = 1'b1;
	logic dutySelectLo = 1'b1;
	logic highDriveModeN = 1'b1;
	logic resetPinN, hreadyout, boosterEnable, regulatorEnable, followerEnable, useInternalDivider;
	logic highPowerMode, oscRunning, serialClear;
	logic [31:0] hrdata, q;
	logic [6:0] regulatorGainX10, dutyDenom;
	logic [5:0] contrastLevel;
	logic [3:0] biasDenom;
	logic [131:0] pixelRow = '0;
	logic [131:0][2:0] segLevel;
	logic [65:0][2:0] comLevel;
	logic alternationSignal, powerSave, staticIndicator, a;
	logic [1:0] indicatorState;
	logic [7:0] pw [4] = '{8'h7, 8'h3, 8'h1, 8'h0};
	logic [6:0] gt [8] = '{7'h1e, 7'h23, 7'h28, 7'h2d, 7'h32, 7'h37, 7'h3c, 7'h40};
	logic [6:0] dd [4] = '{7'h21, 7'h31, 7'h37, 7'h41};
	logic [3:0] b0 [4] = '{4'h6, 4'h8, 4'h8, 4'h9};
	logic [3:0] b1 [4] = '{4'h5, 4'h6, 4'h6, 4'h7};
	localparam logic [31:0] M = 32'h0f41773f;
	int bad_count = 0;
	int comparisons = 0;
	always #2 clk = ~clk;
	lcdr_host host (.hostRstN(rst_n), .pinRstReq, .resetPinN);
	lcdr_top #(.RST_CYC(8), .LINE_DIV(4)) dut (.clk, .rst_n, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .resetPinN, .primarySecondarySelect,
		.internalDividerSelect, .dutySelectHi, .dutySelectLo, .highDriveModeN, .pixelRow, .boosterEnable,
		.regulatorEnable, .followerEnable, .contrastLevel, .dividerRatioCode(), .regulatorGainX10,
		.useInternalDivider, .dutyDenom, .biasDenom, .highPowerMode, .oscRunning, .alternationSignal,
		.lineIndex(), .displayLine(), .serialClear, .powerSave, .staticIndicator, .indicatorState,
		.segLevel, .comLevel);
	// ---------------------------------------------------------------
	// bus tasks
	// ---------------------------------------------------------------
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : bus
	task automatic cmd(input logic [7:0] c);
		bus(1'b1, 8'h00, {24'h0, c});
	endtask : cmd
	task automatic idle();
		do bus(1'b0, 8'h04, 32'h0); while (q[7] !== 1'b0 || q[4] !== 1'b0);
	endtask : idle
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : wrap_up
	// ---------------------------------------------------------------
	// tests
	// ---------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		idle();
		bus(1'b0, 8'h08, 32'h0);
		chk("cfg", 32'h420, q & M);
		$display("test defaults done");
		foreach (pw[i]) begin
			cmd(8'h28 | pw[i]);
			repeat (4) @(posedge clk);
			chk("power", 32'(pw[i]), {29'h0, boosterEnable, regulatorEnable, followerEnable});
		end
		primarySecondarySelect <= 1'b0;
		cmd(8'h2f);
		repeat (6) @(posedge clk);
		chk("power", 32'h0, {29'h0, boosterEnable, regulatorEnable, followerEnable});
		primarySecondarySelect <= 1'b1;
		repeat (6) @(posedge clk);
		chk("power", 32'h7, {29'h0, boosterEnable, regulatorEnable, followerEnable});
		$display("test power done");
		cmd(8'h81);
		cmd(8'h3f);
		// level registers update at the data-phase edge; look one edge later
		@(posedge clk);
		chk("contrast", 32'h3f, {26'h0, contrastLevel});
		bus(1'b0, 8'h08, 32'h0);
		chk("cfg", 32'h743f, q & M);
		$display("test contrast done");
		for (logic [3:0] i = 0; i < 8; i++) begin
			cmd(8'h20 | {5'h0, i[2:0]});
			@(posedge clk);
			chk("gain", 32'(gt[i[2:0]]), {25'h0, regulatorGainX10});
		end
		internalDividerSelect <= 1'b0;
		repeat (6) @(posedge clk);
		chk("extdiv", 32'h0, {24'h0, useInternalDivider, regulatorGainX10});
		internalDividerSelect <= 1'b1;
		$display("test ratio done");
		for (logic [3:0] i = 0; i < 8; i++) begin
			{dutySelectHi, dutySelectLo} <= i[1:0];
			highDriveModeN <= i[2];
			cmd(8'ha2 | {7'h0, i[2]});
			repeat (6) @(posedge clk);
			chk("duty", 32'(dd[i[1:0]]), {25'h0, dutyDenom});
			chk("bias", 32'(i[2] ? b1[i[1:0]] : b0[i[1:0]]), {28'h0, biasDenom});
			chk("hpm", {31'h0, ~i[2]}, {31'h0, highPowerMode});
		end
		$display("test duty done");
		cmd(8'haf);
		cmd(8'h45);
		cmd(8'had);
		cmd(8'h03);
		@(posedge clk);
		chk("ind", 32'h7, {29'h0, staticIndicator, indicatorState});
		cmd(8'he2);
		cmd(8'ha7);
		bus(1'b0, 8'h04, 32'h0);
		chk("status", 32'h90, q & 32'h90);
		idle();
		bus(1'b0, 8'h08, 32'h0);
		chk("cfg", 32'h01017420, q & M);
		chk("ind", 32'h0, {29'h0, staticIndicator, indicatorState});
		bus(1'b0, 8'h0c, 32'h0);
		chk("pos", 32'h0, q & 32'h000fff3f);
		$display("test reset command done");
		pixelRow <= 132'h1;
		@(posedge clk);
		// levels register one edge after the alternation value they use
		a = alternationSignal;
		@(posedge clk);
		chk("seg on", 32'(a ? lcdr_pkg::LV_V0 : lcdr_pkg::LV_VSS), {29'h0, segLevel[0]});
		chk("seg off", 32'(a ? lcdr_pkg::LV_V2 : lcdr_pkg::LV_V3), {29'h0, segLevel[1]});
		{dutySelectHi, dutySelectLo} <= 2'b00;
		repeat (6) @(posedge clk);
		chk("com nc", 32'(lcdr_pkg::LV_NC), {29'h0, comLevel[20]});
		$display("test levels done");
		cmd(8'hae);
		cmd(8'ha5);
		@(posedge clk);
		chk("psave", 32'h1, {31'h0, powerSave});
		pinRstReq <= 1'b1;
		repeat (6) @(posedge clk);
		chk("osc", 32'h1, {30'h0, oscRunning, serialClear});
		bus(1'b0, 8'h04, 32'h0);
		chk("status", 32'h10, q & 32'h10);
		cmd(8'haf);
		pinRstReq <= 1'b0;
		idle();
		bus(1'b0, 8'h08, 32'h0);
		chk("cfg", 32'h420, q & M);
		chk("psave", 32'h0, {31'h0, powerSave});
		$display("test pin reset done");
		wrap_up();
	end
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		wrap_up();
	end
endmodule : lcdr_top_tb
bind lcdr_top lcdr_checker chk (.clk, .rst_n, .resetPinN, .primarySecondarySelect, .highDriveModeN,
	.boosterEnable, .regulatorEnable, .followerEnable, .contrastLevel, .dividerRatioCode, .regulatorGainX10,
	.useInternalDivider, .dutyDenom, .biasDenom, .highPowerMode, .oscRunning, .serialClear);
